/* rtl/qos_monitor_consts.svh */
`ifndef QOS_MONITOR_CONSTS_SVH
`define QOS_MONITOR_CONSTS_SVH

// Register indices; byte address is four times the index
`define QM_IDX_EVSEL    12'hc8d
`define QM_IDX_CTR      12'hc8e
`define QM_IDX_ASSOC    12'hc8f
`define QM_IDX_STATUS   12'hc90
`define QM_IDX_MASK     12'hc91

// Upper 32-bit halves of the 64-bit registers sit this far above
`define QM_HI_OFF       16'h0100

// Field positions
`define QM_EVENT_MSB    7
`define QM_DATA_MSB     61
`define QM_UNAVAIL_BIT  62
`define QM_ERROR_BIT    63

// Interrupt status bits
`define QM_IRQ_BADSEL   0
`define QM_IRQ_UNAVAIL  1
`define QM_IRQ_W        2

// Reset values
`define QM_EVENT_RST    8'h00
`define QM_SEL_ERR_RST  1'h1
`define QM_MASK_RST     2'h0

`endif

/* rtl/qos_monitor_pkg.sv */
package qos_monitor_pkg;

    typedef logic [31:0] word_t;
    typedef logic [15:0] addr_t;
    typedef logic [63:0] ctr_word_t;
    typedef logic [7:0]  event_id_t;

endpackage

/* rtl/qos_sel_check.sv */
`timescale 1ns/1ps
// Decides whether a tag and event pair is one the monitor can report
module qos_sel_check #(
    parameter int unsigned MAX_TAG   = 15,
    parameter int unsigned MAX_EVENT = 1,
    parameter int unsigned TAG_W     = 4
) (
    // Candidate selection
    input  wire qos_monitor_pkg::event_id_t event_id,
    input  wire logic [TAG_W-1:0]           tag,
    // Verdict
    output wire logic                       sel_ok
);
    import qos_monitor_pkg::*;

    wire logic event_ok;
    wire logic tag_ok;

    // Event zero is never a valid event
    assign event_ok = (event_id != 8'h00) && (32'(event_id) <= MAX_EVENT);
    assign tag_ok   = 32'(tag) <= MAX_TAG;
    assign sel_ok   = event_ok && tag_ok;

endmodule // qos_sel_check

/* rtl/qos_irq_status.sv */
`timescale 1ns/1ps
`include "qos_monitor_consts.svh"
// Sticky event bits, cleared by reading them, gated by a mask
module qos_irq_status #(
    parameter int unsigned W = 2
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         ce,
    // Events and software access
    input  wire logic [W-1:0] set_evt,
    input  wire logic         rd_clr,
    input  wire logic         mask_wr,
    input  wire logic [W-1:0] mask_wdata,
    // State
    output logic      [W-1:0] status_r,
    output logic      [W-1:0] mask_r,
    output wire logic         irq
);
    import qos_monitor_pkg::*;

    wire logic [W-1:0] status_nxt;

    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            // Set beats the clear so no event is lost
            assign status_nxt[i] = set_evt[i] | (status_r[i] & ~rd_clr);
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            status_r <= '0;
            mask_r   <= W'(`QM_MASK_RST);
        end
        else if (ce)
        begin
            status_r <= status_nxt;
            if (mask_wr)
                mask_r <= mask_wdata;
        end
    end

    assign irq = |(status_r & mask_r);

endmodule // qos_irq_status

/* rtl/qos_resource_monitor_regs.sv */
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "qos_monitor_consts.svh"

// How it works
// - Selector bits 7:0 pick reported event
// - Selector tag field from bit 32 picks owner
// - Counter is read-only, data in bits 61:0
// - Counter bit 62 flags unavailable data
// - Counter bit 63 flags unsupported selection
// - Association tag attributes core activity
// - Selector reads back last written event and tag
// - Association reads back last written tag
module qos_resource_monitor_regs #(
    parameter int unsigned MAX_TAG   = 15,
    parameter int unsigned MAX_EVENT = 1,
    parameter int unsigned TAG_W     = $clog2(MAX_TAG + 1)
) (
    // Clock, reset, enable
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       ce,
    // APB slave
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire qos_monitor_pkg::addr_t     paddr,
    input  wire qos_monitor_pkg::word_t     pwdata,
    output qos_monitor_pkg::word_t          prdata,
    output wire logic                       pready,
    output wire logic                       pslverr,
    // Monitoring hardware
    output wire logic [TAG_W-1:0]           mon_tag,
    output qos_monitor_pkg::event_id_t      mon_event,
    input  wire logic [`QM_DATA_MSB:0]      mon_data,
    input  wire logic                       mon_avail,
    // Core side
    output wire logic [TAG_W-1:0]           active_tag,
    // Interrupt
    output wire logic                       irq
);
    import qos_monitor_pkg::*;

    // Register state
    event_id_t              sel_event_r;
    logic [TAG_W-1:0]       sel_tag_r;
    logic                   sel_err_r;
    logic [TAG_W-1:0]       assoc_tag_r;
    ctr_word_t              ctr_snap_r;
    word_t                  prdata_r;
    logic                   loaded_r;
    logic                   err_r;
    logic [`QM_IRQ_W-1:0]   status_r;
    logic [`QM_IRQ_W-1:0]   mask_r;

    // Byte addresses
    wire addr_t a_evsel_lo;
    wire addr_t a_ctr_lo;
    wire addr_t a_assoc_lo;
    wire addr_t a_status;
    wire addr_t a_mask;

    assign a_evsel_lo = {2'b00, `QM_IDX_EVSEL, 2'b00};
    assign a_ctr_lo   = {2'b00, `QM_IDX_CTR, 2'b00};
    assign a_assoc_lo = {2'b00, `QM_IDX_ASSOC, 2'b00};
    assign a_status   = {2'b00, `QM_IDX_STATUS, 2'b00};
    assign a_mask     = {2'b00, `QM_IDX_MASK, 2'b00};

    // Address decode
    wire logic hit_evsel_lo;
    wire logic hit_evsel_hi;
    wire logic hit_ctr_lo;
    wire logic hit_ctr_hi;
    wire logic hit_assoc_lo;
    wire logic hit_assoc_hi;
    wire logic hit_status;
    wire logic hit_mask;
    wire logic hit_any;

    assign hit_evsel_lo = paddr == a_evsel_lo;
    assign hit_evsel_hi = paddr == 16'(a_evsel_lo + `QM_HI_OFF);
    assign hit_ctr_lo   = paddr == a_ctr_lo;
    assign hit_ctr_hi   = paddr == 16'(a_ctr_lo + `QM_HI_OFF);
    assign hit_assoc_lo = paddr == a_assoc_lo;
    assign hit_assoc_hi = paddr == 16'(a_assoc_lo + `QM_HI_OFF);
    assign hit_status   = paddr == a_status;
    assign hit_mask     = paddr == a_mask;
    assign hit_any      = hit_evsel_lo | hit_evsel_hi | hit_ctr_lo
                        | hit_ctr_hi | hit_assoc_lo | hit_assoc_hi
                        | hit_status | hit_mask;

    // Transfer phases: the setup cycle loads read data, so the access
    // phase completes at once while ce is high; ce low adds wait states
    wire logic load;
    wire logic wr_now;

    assign load    = ce & psel & ~loaded_r;
    assign pready  = ce & psel & penable & loaded_r;
    assign pslverr = pready & err_r;
    assign wr_now  = pready & pwrite & ~err_r;
    assign prdata  = prdata_r;

    // Writes
    wire logic wr_evsel_lo;
    wire logic wr_evsel_hi;
    wire logic wr_assoc_lo;
    wire logic wr_mask;
    wire logic wr_sel;

    assign wr_evsel_lo = wr_now & hit_evsel_lo;
    assign wr_evsel_hi = wr_now & hit_evsel_hi;
    assign wr_assoc_lo = wr_now & hit_assoc_lo;
    assign wr_mask     = wr_now & hit_mask;
    assign wr_sel      = wr_evsel_lo | wr_evsel_hi;

    // Candidate selection after a write; reserved bits dropped
    wire event_id_t        event_nxt;
    wire logic [TAG_W-1:0] tag_nxt;
    wire logic             nxt_ok;

    assign event_nxt = wr_evsel_lo ? pwdata[`QM_EVENT_MSB:0]
                                   : sel_event_r;
    assign tag_nxt   = wr_evsel_hi ? pwdata[TAG_W-1:0]
                                   : sel_tag_r;

    qos_sel_check #(
        .MAX_TAG   (MAX_TAG),
        .MAX_EVENT (MAX_EVENT),
        .TAG_W     (TAG_W)
    ) i_qos_sel_check (
        .event_id (event_nxt),
        .tag      (tag_nxt),
        .sel_ok   (nxt_ok)
    );

    // Live counter word; data forced to zero on a bad selection
    wire ctr_word_t            ctr_live;
    wire logic [`QM_DATA_MSB:0] data_sel;

    assign data_sel = sel_err_r ? '0 : mon_data;
    assign ctr_live = {sel_err_r, ~mon_avail, data_sel};

    // Read data selection
    wire word_t rdata_mux;
    wire word_t tag_word;
    wire word_t assoc_word;

    assign tag_word   = {{(32-TAG_W){1'b0}}, sel_tag_r};
    assign assoc_word = {{(32-TAG_W){1'b0}}, assoc_tag_r};
    assign rdata_mux  =
        hit_evsel_lo ? {24'h00_0000, sel_event_r} :
        hit_evsel_hi ? tag_word :
        hit_ctr_lo   ? ctr_live[31:0] :
        hit_ctr_hi   ? ctr_snap_r[63:32] :
        hit_assoc_lo ? assoc_word :
        hit_status   ? {30'h0000_0000, status_r} :
        hit_mask     ? {30'h0000_0000, mask_r} :
                       32'h0000_0000;

    // Unmapped addresses and writes to the counter are refused
    wire logic bad_access;

    assign bad_access = ~hit_any | (pwrite & (hit_ctr_lo | hit_ctr_hi));

    // Interrupt events
    wire logic [`QM_IRQ_W-1:0] set_evt;
    wire logic                 rd_status;

    assign set_evt[`QM_IRQ_BADSEL]  = wr_sel & ~nxt_ok;
    assign set_evt[`QM_IRQ_UNAVAIL] = load & ~pwrite & hit_ctr_lo
                                    & ~mon_avail;
    assign rd_status = load & ~pwrite & hit_status;

    qos_irq_status #(
        .W (`QM_IRQ_W)
    ) i_qos_irq_status (
        .pclk       (pclk),
        .presetn    (presetn),
        .ce         (ce),
        .set_evt    (set_evt),
        .rd_clr     (rd_status),
        .mask_wr    (wr_mask),
        .mask_wdata (pwdata[`QM_IRQ_W-1:0]),
        .status_r   (status_r),
        .mask_r     (mask_r),
        .irq        (irq)
    );

    // Bus phase state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            loaded_r <= 1'b0;
            err_r    <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end
        else if (load)
        begin
            loaded_r <= 1'b1;
            err_r    <= bad_access;
            prdata_r <= pwrite ? 32'h0000_0000 : rdata_mux;
        end
        else if (pready)
        begin
            loaded_r <= 1'b0;
        end
    end

    // Low word read freezes the whole counter so the high half matches
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctr_snap_r <= '0;
        else if (load && !pwrite && hit_ctr_lo)
            ctr_snap_r <= ctr_live;
    end

    // Selection
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sel_event_r <= `QM_EVENT_RST;
            sel_tag_r   <= '0;
            sel_err_r   <= `QM_SEL_ERR_RST;
        end
        else if (wr_sel)
        begin
            sel_event_r <= event_nxt;
            sel_tag_r   <= tag_nxt;
            sel_err_r   <= ~nxt_ok;
        end
    end

    // Association of running work with a tag
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            assoc_tag_r <= '0;
        else if (wr_assoc_lo)
            assoc_tag_r <= pwdata[TAG_W-1:0];
    end

    assign mon_tag    = sel_tag_r;
    assign mon_event  = sel_event_r;
    assign active_tag = assoc_tag_r;

    // Checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_event_write;
        wr_evsel_lo |=> mon_event == $past(pwdata[7:0]);
    endproperty
    a_event_write: assert property (p_event_write)
        else $error("event id not taken from write");

    property p_tag_write;
        wr_evsel_hi |=> mon_tag == $past(pwdata[TAG_W-1:0]);
    endproperty
    a_tag_write: assert property (p_tag_write)
        else $error("selector tag not taken from write");

    property p_ctr_read;
        (load && !pwrite && hit_ctr_lo)
            |=> prdata == $past(data_sel[31:0])
                && ctr_snap_r == $past(ctr_live);
    endproperty
    a_ctr_read: assert property (p_ctr_read)
        else $error("counter read data wrong");

    property p_unavail;
        (load && !pwrite && hit_ctr_lo && !mon_avail)
            |=> ctr_snap_r[62] && status_r[`QM_IRQ_UNAVAIL];
    endproperty
    a_unavail: assert property (p_unavail)
        else $error("unavailable flag not raised");

    property p_bad_event;
        (wr_evsel_lo && pwdata[7:0] == 8'h00)
            |=> ctr_live[63] && status_r[`QM_IRQ_BADSEL];
    endproperty
    a_bad_event: assert property (p_bad_event)
        else $error("error flag not raised for bad event");

    property p_assoc_write;
        wr_assoc_lo |=> active_tag == $past(pwdata[TAG_W-1:0]);
    endproperty
    a_assoc_write: assert property (p_assoc_write)
        else $error("association tag not taken from write");

    property p_sel_readback;
        (load && !pwrite && hit_evsel_lo)
            |=> prdata == {24'h00_0000, mon_event};
    endproperty
    a_sel_readback: assert property (p_sel_readback)
        else $error("selector readback mismatch");

    property p_assoc_hold;
        !wr_assoc_lo |=> $stable(active_tag);
    endproperty
    a_assoc_hold: assert property (p_assoc_hold)
        else $error("association tag changed without write");

    property p_reserved_zero;
        (load && !pwrite && (hit_evsel_hi || hit_assoc_lo))
            |=> prdata[31:TAG_W] == '0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bits not zero");

    property p_ctr_high;
        (load && !pwrite && hit_ctr_hi)
            |=> prdata == $past(ctr_snap_r[63:32]);
    endproperty
    a_ctr_high: assert property (p_ctr_high)
        else $error("counter high word not from snapshot");

    property p_ctr_refused;
        (pready && pwrite && (hit_ctr_lo || hit_ctr_hi))
            |-> pslverr && !wr_now;
    endproperty
    a_ctr_refused: assert property (p_ctr_refused)
        else $error("counter write not refused");

    property p_sel_hold;
        !wr_sel |=> $stable(mon_event) && $stable(mon_tag);
    endproperty
    a_sel_hold: assert property (p_sel_hold)
        else $error("selection changed without write");

    property p_sel_error;
        wr_sel |=> ctr_live[63] == !$past(nxt_ok);
    endproperty
    a_sel_error: assert property (p_sel_error)
        else $error("error flag does not follow selection");

    property p_assoc_readback;
        (load && !pwrite && hit_assoc_lo)
            |=> prdata == 32'(active_tag);
    endproperty
    a_assoc_readback: assert property (p_assoc_readback)
        else $error("association readback mismatch");

    property p_reserved_write;
        (pready && pwrite && (hit_assoc_hi || hit_evsel_hi))
            |-> !pslverr;
    endproperty
    a_reserved_write: assert property (p_reserved_write)
        else $error("reserved write refused");

endmodule // qos_resource_monitor_regs

/* bench/tb_qos_resource_monitor_regs.sv */
`timescale 1ns/1ps
`include "qos_monitor_consts.svh"
module tb_qos_resource_monitor_regs;
    import qos_monitor_pkg::*;

    localparam int unsigned MAX_EVENT = 1;
    localparam addr_t A_SEL = addr_t'(`QM_IDX_EVSEL) << 2;
    localparam addr_t A_CTR = addr_t'(`QM_IDX_CTR) << 2;
    localparam addr_t A_ASC = addr_t'(`QM_IDX_ASSOC) << 2;
    localparam addr_t A_STA = addr_t'(`QM_IDX_STATUS) << 2;
    localparam addr_t A_MSK = addr_t'(`QM_IDX_MASK) << 2;
    localparam addr_t HI    = `QM_HI_OFF;

    // Clock, reset and bus
    logic                   pclk;
    logic                   presetn;
    logic                   ce;
    logic                   psel;
    logic                   penable;
    logic                   pwrite;
    addr_t                  paddr;
    word_t                  pwdata;
    word_t                  prdata;
    logic                   pready;
    logic                   pslverr;
    // Monitoring side
    logic [3:0]             mon_tag;
    event_id_t              mon_event;
    logic [`QM_DATA_MSB:0]  mon_data;
    logic                   mon_avail;
    logic [3:0]             active_tag;
    logic                   irq;

    int                     mismatches;
    int                     samples_checked;
    logic [33:0]            exp_q[$];
    logic [31:0]            rnd;
    logic                   sel_err;
    logic [1:0]             st;
    logic [1:0]             msk;

    qos_resource_monitor_regs i_qos_resource_monitor_regs (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mon_tag(mon_tag), .mon_event(mon_event),
        .mon_data(mon_data), .mon_avail(mon_avail),
        .active_tag(active_tag), .irq(irq)
    );

    always #20 pclk = ~pclk;

    function automatic logic [31:0] xs();
        rnd = rnd ^ (rnd << 13);
        rnd = rnd ^ (rnd >> 17);
        rnd = rnd ^ (rnd << 5);
        return rnd;
    endfunction

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        if (mismatches == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // One transfer with one idle cycle after it; the request stands
    // until the rising edge at which pready is seen high
    task automatic apb(input logic wr, input addr_t a, input word_t d,
                       input logic err, input word_t exp, input int stall);
        exp_q.push_back({~wr, err, exp});
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        if (stall > 0)
        begin
            ce <= 1'b0;
            repeat (stall) @(posedge pclk);
            ce <= 1'b1;
        end
        @(posedge pclk);
        while (!pready) @(posedge pclk);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd(input addr_t a, input word_t e);
        apb(1'b0, a, 32'h0000_0000, 1'b0, e, 0);
    endtask

    task automatic wsel(input event_id_t ev, input logic [3:0] tag);
        sel_err = (ev < 1) || (ev > MAX_EVENT);
        apb(1'b1, A_SEL, {24'hff_ffff, ev}, 1'b0, 32'h0, 0);
        apb(1'b1, A_SEL + HI, {28'hfff_ffff, tag}, 1'b0, 32'h0, 0);
        if (sel_err)
            st[0] = 1'b1;
        rd(A_SEL, {24'h00_0000, ev});
        rd(A_SEL + HI, {28'h000_0000, tag});
        chk({56'h0, mon_event}, {56'h0, ev});
        chk({60'h0, mon_tag}, {60'h0, tag});
    endtask

    task automatic rd_ctr(input logic [61:0] d, input logic av,
                          input int stall);
        logic [61:0] v;
        v = sel_err ? 62'h0 : d;
        mon_data  <= d;
        mon_avail <= av;
        apb(1'b0, A_CTR, 32'h0, 1'b0, v[31:0], stall);
        if (!av)
            st[1] = 1'b1;
        apb(1'b0, A_CTR + HI, 32'h0, 1'b0,
            {sel_err, ~av, v[61:32]}, 0);
    endtask

    // Scoreboard: every completed transfer retires the oldest note
    always @(posedge pclk)
    begin
        if (psel && penable && pready)
        begin
            if (exp_q.size() == 0)
                chk({63'h0, pready}, 64'h0);
            else
            begin
                chk({63'h0, pslverr}, {63'h0, exp_q[0][32]});
                if (exp_q[0][33])
                    chk({32'h0, prdata}, {32'h0, exp_q[0][31:0]});
                void'(exp_q.pop_front());
            end
        end
    end

    initial
    begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        test_done();
    end

    initial
    begin
        pclk = 0; presetn = 0; ce = 1; psel = 0; penable = 0; pwrite = 0;
        paddr = 0; pwdata = 0; mon_data = 0; mon_avail = 1;
        mismatches = 0; samples_checked = 0; rnd = 32'h3cb2_a8c9;
        sel_err = 1; st = 0; msk = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(A_SEL, 32'h0000_0000);
        rd_ctr(62'(xs()), 1'b1, 0);
        for (int ev = 0; ev < 4; ev++)
        begin
            wsel(event_id_t'(ev), 4'(xs()));
            rd_ctr({30'(xs()), xs()}, 1'b1, ev);
        end
        wsel(8'h01, 4'hf);
        for (int i = 0; i < 4; i++)
            rd_ctr({30'(xs()), xs()}, 1'(xs()), 1);
        apb(1'b1, A_CTR, xs(), 1'b1, 32'h0, 0);
        apb(1'b1, A_STA + 16'h0008, xs(), 1'b1, 32'h0, 0);
        rd_ctr({30'(xs()), xs()}, 1'b1, 0);
        apb(1'b1, A_ASC, 32'hffff_fffa, 1'b0, 32'h0, 0);
        apb(1'b1, A_ASC + HI, 32'hffff_ffff, 1'b0, 32'h0, 0);
        rd(A_ASC, 32'h0000_000a);
        rd(A_ASC + HI, 32'h0000_0000);
        chk({60'h0, active_tag}, 64'h0000_0000_0000_000a);
        rd(A_STA, 32'(st));
        st = 0;
        chk({63'h0, irq}, 64'h0);
        // Unavailable event while masked must stay quiet
        apb(1'b1, A_MSK, 32'h0000_0000, 1'b0, 32'h0, 0);
        rd_ctr({30'(xs()), xs()}, 1'b0, 0);
        chk({63'h0, irq}, 64'h0);
        apb(1'b1, A_MSK, 32'h0000_0002, 1'b0, 32'h0, 0);
        rd(A_MSK, 32'h0000_0002);
        chk({63'h0, irq}, 64'h1);
        rd(A_STA, 32'(st));
        st = 0;
        chk({63'h0, irq}, 64'h0);
        // Bad selection raises the other source
        apb(1'b1, A_MSK, 32'h0000_0001, 1'b0, 32'h0, 0);
        wsel(8'h02, 4'h3);
        chk({63'h0, irq}, 64'h1);
        rd_ctr({30'(xs()), xs()}, 1'b1, 2);
        rd(A_STA, 32'(st));
        chk({63'h0, irq}, 64'h0);
        rd(A_STA, 32'h0000_0000);
        // Reset in mid-run must bring back the idle register values
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        sel_err = 1'b1;
        @(posedge pclk);
        chk({60'h0, active_tag}, 64'h0);
        rd(A_SEL + HI, 32'h0000_0000);
        rd(A_MSK, 32'h0000_0000);
        rd_ctr(62'(xs()), 1'b1, 0);
        test_done();
    end
endmodule // tb_qos_resource_monitor_regs
